// ### bench/rco_chk.sv
// checker: bus answer and reference clock pin properties
// assumes one-word writes whose data phase follows at once
`timescale 1ns/1ps
`default_nettype none
module rco_chk (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        sleep_mode,
   input wire logic        ref_clock_out_pin,
   input wire logic        ref_clock_internal
);
   logic       wc_q;
   logic       ws_q;
   logic [7:0] ctl_q;
   logic [3:0] src_q;
   logic [3:0] qt_q;
   wire        wr  = hsel && hready && htrans[1] && hwrite;
   wire        en  = ctl_q[7];
   wire        pin = ref_clock_out_pin;
   // shadow registers; qt_q counts quiet cycles since a change
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wc_q  <= 1'b0;
         ws_q  <= 1'b0;
         ctl_q <= 8'h10;
         src_q <= 4'h0;
         qt_q  <= 4'h0;
      end else begin
         wc_q <= wr && haddr == 32'ha58;
         ws_q <= wr && haddr == 32'ha5c;
         if (wc_q)
            ctl_q <= hwdata[7:0] & 8'h9f;
         if (ws_q)
            src_q <= hwdata[3:0];
         if (wc_q || ws_q || sleep_mode)
            qt_q <= 4'h0;
         else if (qt_q != 4'hf)
            qt_q <= qt_q + 4'h1;
      end
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   bus_okay_a: assert property (hreadyout && !hresp)
      else $error("bus not ready or not okay");
   int_copy_a: assert property (ref_clock_internal == pin)
      else $error("internal clock differs from pin");
   off_low_a: assert property (!en |-> !pin)
      else $error("pin high while disabled");
   start_low_a: assert property ($rose(en) |-> !pin [*2])
      else $error("pin not low at start");
   rsv_low_a: assert property (src_q >= 4'hc && qt_q > 4'h2 |-> !pin)
      else $error("pin high on reserved source");
   sleep_low_a: assert property (
      (sleep_mode && src_q == 4'h0) [*4] |-> !pin)
      else $error("pin high in sleep on system source");
   zero_duty_a: assert property (en && ctl_q[2:0] != 3'h0 &&
      ctl_q[4:3] == 2'h0 && qt_q > 4'h2 |-> !pin)
      else $error("pin high at zero duty");
   div_one_a: assert property (en && ctl_q[2:0] == 3'h0 &&
      src_q == 4'h0 && qt_q > 4'h8 && !wc_q && !ws_q
      |=> pin != $past(pin))
      else $error("pin not toggling at divide one");
   cover property (en && ctl_q[2:0] == 3'h7 && pin);
   cover property (sleep_mode && en && src_q != 4'h0 && pin);
   cover property ($rose(en) && src_q >= 4'hc);
endmodule
`default_nettype wire

// ### bench/rco_clk_sink.sv
// peripheral model: times the reference clock that it receives
// assumes that clock is at most half of clk
`timescale 1ns/1ps
`default_nettype none
module rco_clk_sink (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        ref_in,
   output logic      [15:0] rises,
   output logic      [15:0] per,
   output logic      [15:0] hi
);
   logic        prev_q;
   logic [15:0] pc_q;
   logic [15:0] hc_q;
   // a consumer sees only edges, so count from one rise to the next
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_q <= 1'b0;
         rises  <= 16'h0;
         per    <= 16'h0;
         hi     <= 16'h0;
         pc_q   <= 16'h0;
         hc_q   <= 16'h0;
      end else begin
         prev_q <= ref_in;
         pc_q   <= pc_q + 16'h1;
         hc_q   <= hc_q + {15'h0, ref_in};
         if (ref_in && !prev_q) begin
            rises <= rises + 16'h1;
            per   <= pc_q;
            hi    <= hc_q;
            pc_q  <= 16'h1;
            hc_q  <= 16'h1;
         end
      end
   end
endmodule
`default_nettype wire

// ### bench/testbench.sv
// bench top: bus tasks, divider and duty sweep, sources, sleep
// assumes the slave answers every transfer ready and okay
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam logic [31:0] CTL = 32'ha58;
   localparam logic [31:0] SRC = 32'ha5c;
   localparam logic [31:0] STA = 32'ha60;
   logic        hclk = 1'b0;
   logic        hresetn, hsel, hwrite, sleep_mode, osc, hready;
   logic [1:0]  htrans;
   logic [31:0] haddr, hwdata, hrdata, r;
   logic        hreadyout, hresp, pin, pin_int;
   logic [15:0] rises, per, hi, r0;
   int          n_fail, cmp_count, cyc;
   assign hready = hreadyout;
   rco_top dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .internal_fast_osc(osc), .internal_slow_osc(osc),
      .internal_medium_osc(osc), .internal_medium_osc_low(osc),
      .secondary_osc(osc), .external_osc(osc),
      .osc_controller_output(osc), .logic_cell_one_output(osc),
      .logic_cell_two_output(osc), .logic_cell_three_output(osc),
      .logic_cell_four_output(osc), .sleep_mode(sleep_mode),
      .ref_clock_out_pin(pin), .ref_clock_internal(pin_int));
   rco_clk_sink sink (.clk(hclk), .rst_n(hresetn), .ref_in(pin_int),
      .rises(rises), .per(per), .hi(hi));
   always #5 hclk = ~hclk;
   // source clock unrelated in phase, slower than half of hclk
   always #37 osc = ~osc;
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         final_report();
      end
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // waits as long as the slave stalls; only the cycle ceiling ends it
   task automatic wait_rdy;
      @(posedge hclk);
      while (hready !== 1'b1) begin
         @(posedge hclk);
      end
   endtask
   task automatic bus(input logic w, input logic [31:0] a,
                      input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      wait_rdy();
      r = hrdata;
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(r, e);
   endtask
   task automatic src_run(input int s, input logic e);
      wr(SRC, 32'(s));
      wr(CTL, 32'h91);
      r0 = rises;
      repeat (80) @(posedge hclk);
      chk(32'(rises != r0), {31'h0, e});
      wr(CTL, 32'h11);
   endtask
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      hwrite = 1'b0;
      htrans = 2'b00;
      haddr = 32'h0;
      hwdata = 32'h0;
      sleep_mode = 1'b0;
      osc = 1'b0;
      n_fail = 0;
      cmp_count = 0;
      cyc = 0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd_chk(CTL, 32'h10);
      rd_chk(SRC, 32'h0);
      wr(CTL, 32'h7f);
      rd_chk(CTL, 32'h1f);
      wr(SRC, 32'hff);
      rd_chk(SRC, 32'hf);
      wr(32'ha64, 32'hff);
      rd_chk(32'ha64, 32'h0);
      wr(SRC, 32'h0);
      // shape change while running raises the sticky live flag
      wr(CTL, 32'h91);
      wr(CTL, 32'h92);
      wr(CTL, 32'h12);
      rd_chk(CTL, 32'h12);
      rd_chk(STA, 32'h8);
      wr(STA, 32'h8);
      rd_chk(STA, 32'h0);
      // a source swap while running raises it too
      wr(CTL, 32'h91);
      wr(SRC, 32'h1);
      wr(CTL, 32'h11);
      wr(SRC, 32'h0);
      rd_chk(STA, 32'h8);
      wr(STA, 32'h8);
      // reserved source parks the block in hold
      wr(SRC, 32'hc);
      wr(CTL, 32'h91);
      rd_chk(SRC, 32'hc);
      rd_chk(STA, 32'h4);
      wr(CTL, 32'h11);
      wr(SRC, 32'h0);
      $display("test registers done");
      for (int v = 0; v < 8; v++) begin
         for (int c = 0; c < 4; c++) begin
            wr(CTL, 32'(c * 8 + v));
            wr(CTL, 32'(128 + c * 8 + v));
            r0 = rises;
            repeat (3 * (2 << v) + 12) @(posedge hclk);
            if (v != 0 && c == 0)
               chk(32'(rises - r0), 32'h0);
            else begin
               chk(32'(per), 32'(2 << v));
               chk(32'(hi), 32'(v == 0 ? 1 : ((1 << v) * c) / 2));
            end
            wr(CTL, 32'(c * 8 + v));
            #1 chk(32'(pin), 32'h0);
            @(posedge hclk);
         end
      end
      $display("test divider and duty done");
      for (int s = 1; s < 16; s++)
         src_run(s, s < 12);
      $display("test sources done");
      sleep_mode <= 1'b1;
      src_run(0, 1'b0);
      src_run(6, 1'b1);
      sleep_mode <= 1'b0;
      src_run(0, 1'b1);
      $display("test sleep done");
      // reset in mid-run while the block is running
      wr(SRC, 32'h6);
      wr(CTL, 32'h80);
      repeat (10) @(posedge hclk);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd_chk(CTL, 32'h10);
      rd_chk(SRC, 32'h0);
      $display("test reset done");
      final_report();
   end
endmodule
bind rco_top rco_chk u_chk (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .sleep_mode(sleep_mode),
   .ref_clock_out_pin(ref_clock_out_pin),
   .ref_clock_internal(ref_clock_internal));
`default_nettype wire

// ### logic/rco_consts.vh
// constants of the reference clock output block: register indices,
// field positions, reset values and source codes.
// assumes it is included once per file by its bare name.
//
// How it works
// - enable starts output with full first pulse
// - clearing enable drops output at once
// - divider field divides base clock by 2^n, system source hclk by 2^(n+1)
// - duty field picks 0, 25, 50, 75 percent
// - divider zero forces fifty percent duty
// - duty field resets to binary 10
// - sleep stops output only for system source
// - source field picks one of twelve clocks
// - divided clock also goes to internal peripherals
// - enable bit 7, duty 4:3, divider 2:0
`ifndef RCO_CONSTS_VH
`define RCO_CONSTS_VH

// register indices; byte address is four times the index
`define RCO_CTRL_IDX    12'h296
`define RCO_SRC_IDX     12'h297
`define RCO_STAT_IDX    12'h298

// control register fields
`define RCO_EN_BIT      7
`define RCO_DC_HI       4
`define RCO_DC_LO       3
`define RCO_DIV_HI      2
`define RCO_DIV_LO      0
`define RCO_CTRL_RST    8'h10

// source select register
`define RCO_SRC_RST     4'h0
`define RCO_SRC_SYS     4'h0
`define RCO_SRC_RSV_MIN 4'hc
`define RCO_SRC_NUM     12

// duty codes
`define RCO_DC_75       2'h3
`define RCO_DC_50       2'h2
`define RCO_DC_25       2'h1
`define RCO_DC_0        2'h0

// status register bits
`define RCO_ST_RUN_BIT  0
`define RCO_ST_OUT_BIT  1
`define RCO_ST_HOLD_BIT 2
`define RCO_ST_LIVE_BIT 3

`endif

// ### logic/rco_pulse_gen.v
// divider and duty shaper: counts base-clock edge ticks and forms the
// output level. assumes tick is a one-cycle pulse on every base edge.
`timescale 1ns/1ps
`default_nettype none
`include "rco_consts.vh"
module rco_pulse_gen #(
   parameter CNT_W = 8
) (
   input  wire       clk,
   input  wire       rst_n,
   input  wire       run,
   input  wire       tick,
   input  wire [2:0] div,
   input  wire [1:0] duty,
   output reg        level_q
);
   reg  [CNT_W-1:0] cnt_q;
   reg              started_q;
   wire [CNT_W:0]   half = {{CNT_W{1'b0}}, 1'b1} << div;
   wire [CNT_W:0]   last = (half << 1) - {{CNT_W{1'b0}}, 1'b1};
   wire [CNT_W-1:0] cnt_nx;
   reg  [CNT_W:0]   thr;

   // one base period is two ticks, so the output period is 2*2^div ticks
   assign cnt_nx = ({1'b0, cnt_q} == last) ? {CNT_W{1'b0}}
                                           : cnt_q + 1'b1;

   always @* begin
      thr = half;
      if (div != 3'h0) begin
         case (duty)
            `RCO_DC_75: thr = half + (half >> 1);
            `RCO_DC_50: thr = half;
            `RCO_DC_25: thr = half >> 1;
            default:    thr = {(CNT_W+1){1'b0}};
         endcase
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q     <= {CNT_W{1'b0}};
         started_q <= 1'b0;
         level_q   <= 1'b0;
      end else if (!run) begin
         // stopped: restart from the period start so no runt pulse
         cnt_q     <= {CNT_W{1'b0}};
         started_q <= 1'b0;
         level_q   <= 1'b0;
      end else if (tick) begin
         if (!started_q) begin
            started_q <= 1'b1;
            cnt_q     <= {CNT_W{1'b0}};
            level_q   <= (thr != {(CNT_W+1){1'b0}});
         end else begin
            cnt_q   <= cnt_nx;
            level_q <= ({1'b0, cnt_nx} < thr);
         end
      end
   end
endmodule
`default_nettype wire

// ### logic/rco_sync.v
// two flip-flop synchroniser for one level from another clock domain.
// assumes d is asynchronous to clk; only q may be read.
`timescale 1ns/1ps
`default_nettype none
module rco_sync (
   input  wire clk,
   input  wire rst_n,
   input  wire d,
   output wire q
);
   reg meta_q;
   reg sync_q;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= d;
         sync_q <= meta_q;
      end
   end

   assign q = sync_q;
endmodule
`default_nettype wire

// ### logic/rco_top.v
// reference clock output: ahb-lite register slave, source selection,
// divider and duty shaping, pin and internal clock outputs.
// assumes one hclk domain; oscillator and logic cell inputs are
// asynchronous levels; sleep_mode comes from logic on hclk.
`timescale 1ns/1ps
`default_nettype none
`include "rco_consts.vh"
module rco_top (
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output wire [31:0] hrdata,
   output wire        hreadyout,
   output wire        hresp,
   input  wire        internal_fast_osc,
   input  wire        internal_slow_osc,
   input  wire        internal_medium_osc,
   input  wire        internal_medium_osc_low,
   input  wire        secondary_osc,
   input  wire        external_osc,
   input  wire        osc_controller_output,
   input  wire        logic_cell_one_output,
   input  wire        logic_cell_two_output,
   input  wire        logic_cell_three_output,
   input  wire        logic_cell_four_output,
   input  wire        sleep_mode,
   output wire        ref_clock_out_pin,
   output wire        ref_clock_internal
);
   localparam [1:0] ST_OFF  = 2'h0;
   localparam [1:0] ST_ARM  = 2'h1;
   localparam [1:0] ST_RUN  = 2'h2;
   localparam [1:0] ST_HOLD = 2'h3;

   // source codes at and above the reserved floor feed nothing
   function is_reserved;
      input [3:0] code;
      begin
         is_reserved = (code >= `RCO_SRC_RSV_MIN);
      end
   endfunction

   // misaligned or out-of-window addresses fold onto an unmapped index
   function [11:0] word_index;
      input [31:0] addr;
      begin
         if (addr[31:14] == 18'h0 && addr[1:0] == 2'h0) begin
            word_index = addr[13:2];
         end else begin
            word_index = 12'h0;
         end
      end
   endfunction

   // ------------------------------------------------------------------
   // bus slave
   // ------------------------------------------------------------------
   reg  [31:0] hrdata_q;
   reg         hreadyout_q;
   reg         hresp_q;
   reg         wr_pend_q;
   reg  [11:0] wr_idx_q;
   reg  [7:0]  ctrl_q;
   reg  [7:0]  ctrl_d;
   reg  [3:0]  src_q;
   reg  [3:0]  src_d;
   reg         live_q;
   reg         live_d;
   reg  [31:0] rd_val;
   reg         wr_ctrl;
   reg         wr_src;
   reg         wr_stat;
   wire        addr_ok;
   wire [11:0] addr_idx;

   // hsize is not checked: only whole-word transfers are expected
   assign addr_ok  = hsel & hready & htrans[1];
   assign addr_idx = word_index(haddr);

   // a write lands one edge after its address phase, with hwdata
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_idx_q  <= 12'h0;
      end else begin
         wr_pend_q <= addr_ok & hwrite;
         if (addr_ok) begin
            wr_idx_q <= addr_idx;
         end
      end
   end

   always @* begin
      ctrl_d  = ctrl_q;
      src_d   = src_q;
      live_d  = live_q;
      wr_ctrl = wr_pend_q & (wr_idx_q == `RCO_CTRL_IDX);
      wr_src  = wr_pend_q & (wr_idx_q == `RCO_SRC_IDX);
      wr_stat = wr_pend_q & (wr_idx_q == `RCO_STAT_IDX);
      if (wr_ctrl) begin
         ctrl_d = {hwdata[`RCO_EN_BIT], 2'b00,
                   hwdata[`RCO_DC_HI:`RCO_DC_LO],
                   hwdata[`RCO_DIV_HI:`RCO_DIV_LO]};
      end
      if (wr_src) begin
         src_d = hwdata[3:0];
      end
      if (wr_stat && hwdata[`RCO_ST_LIVE_BIT]) begin
         live_d = 1'b0;
      end
      // a shape change while running may glitch; flag it, set wins
      if (wr_ctrl && ctrl_q[`RCO_EN_BIT] &&
          hwdata[`RCO_EN_BIT] &&
          hwdata[`RCO_DC_HI:0] != ctrl_q[`RCO_DC_HI:0]) begin
         live_d = 1'b1;
      end
      // a source swap while running may cut a pulse short as well
      if (wr_src && ctrl_q[`RCO_EN_BIT] &&
          hwdata[3:0] != src_q) begin
         live_d = 1'b1;
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q <= `RCO_CTRL_RST;
         src_q  <= `RCO_SRC_RST;
         live_q <= 1'b0;
      end else begin
         ctrl_q <= ctrl_d;
         src_q  <= src_d;
         live_q <= live_d;
      end
   end

   // ------------------------------------------------------------------
   // source synchronisers and edge ticks
   // ------------------------------------------------------------------
   wire [`RCO_SRC_NUM-1:1] src_async;
   wire [`RCO_SRC_NUM-1:1] src_sync;
   reg  [`RCO_SRC_NUM-1:1] src_prev_q;
   wire [15:0]             tick_all;

   assign src_async = {logic_cell_four_output,
                       logic_cell_three_output,
                       logic_cell_two_output,
                       logic_cell_one_output,
                       osc_controller_output,
                       external_osc,
                       secondary_osc,
                       internal_medium_osc_low,
                       internal_medium_osc,
                       internal_slow_osc,
                       internal_fast_osc};

   // the system source is hclk itself: every cycle counts as an edge
   assign tick_all[0] = 1'b1;
   // reserved codes never tick
   assign tick_all[15:`RCO_SRC_NUM] = {(16-`RCO_SRC_NUM){1'b0}};

   // each source is an unrelated clock: two flops, then edge detect
   genvar gi;
   generate
      for (gi = 1; gi < `RCO_SRC_NUM; gi = gi + 1) begin : g_src
         rco_sync u_sync (
            .clk   (hclk),
            .rst_n (hresetn),
            .d     (src_async[gi]),
            .q     (src_sync[gi])
         );

         // both edges count; sources slower than hclk/2 only
         assign tick_all[gi] = src_sync[gi] ^ src_prev_q[gi];
      end
   endgenerate

   // one process keeps all edge history so each bit has one driver
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         src_prev_q <= {(`RCO_SRC_NUM-1){1'b0}};
      end else begin
         src_prev_q <= src_sync;
      end
   end

   // codes at and above the reserved floor select a zero tick
   wire tick_sel;

   assign tick_sel = tick_all[src_q];

   // ------------------------------------------------------------------
   // enable sequencing
   // ------------------------------------------------------------------
   reg  [1:0] st_q;
   reg  [1:0] st_d;
   wire       en;
   wire       stall;
   wire       run;

   assign en    = ctrl_q[`RCO_EN_BIT];
   // the system source is taken as stopped in sleep, so hold the pin
   assign stall = is_reserved(src_q) |
                  (sleep_mode & (src_q == `RCO_SRC_SYS));

   always @* begin
      st_d = st_q;
      case (st_q)
         ST_OFF: begin
            if (en) begin
               st_d = stall ? ST_HOLD : ST_ARM;
            end
         end
         ST_ARM: begin
            if (!en) begin
               st_d = ST_OFF;
            end else if (stall) begin
               st_d = ST_HOLD;
            end else if (tick_sel) begin
               // the first count starts on a base edge
               st_d = ST_RUN;
            end
         end
         ST_RUN: begin
            if (!en) begin
               st_d = ST_OFF;
            end else if (stall) begin
               st_d = ST_HOLD;
            end
         end
         ST_HOLD: begin
            if (!en) begin
               st_d = ST_OFF;
            end else if (!stall) begin
               // resume through arm so the first pulse is whole
               st_d = ST_ARM;
            end
         end
         default: begin
            st_d = ST_OFF;
         end
      endcase
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q <= ST_OFF;
      end else begin
         st_q <= st_d;
      end
   end

   // run falls with enable or a stall, never waiting for a period end
   assign run = en & ~stall & ((st_q == ST_ARM) | (st_q == ST_RUN));

   // ------------------------------------------------------------------
   // divider and duty
   // ------------------------------------------------------------------
   wire gen_level;

   rco_pulse_gen #(
      .CNT_W (8)
   ) u_gen (
      .clk     (hclk),
      .rst_n   (hresetn),
      .run     (run),
      .tick    (tick_sel),
      .div     (ctrl_q[`RCO_DIV_HI:`RCO_DIV_LO]),
      .duty    (ctrl_q[`RCO_DC_HI:`RCO_DC_LO]),
      .level_q (gen_level)
   );

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------
   reg pin_q;
   reg int_q;

   // gated by run, the shaper and the next-state enable bit so disable drops at once
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_q <= 1'b0;
         int_q <= 1'b0;
      end else begin
         pin_q <= gen_level & run & ctrl_d[`RCO_EN_BIT];
         int_q <= gen_level & run & ctrl_d[`RCO_EN_BIT];
      end
   end

   assign ref_clock_out_pin  = pin_q;
   assign ref_clock_internal = int_q;

   // ------------------------------------------------------------------
   // read data, taken from next-state values so a read right after a
   // write sees the new contents
   // ------------------------------------------------------------------
   always @* begin
      rd_val = 32'h0;
      case (addr_idx)
         `RCO_CTRL_IDX: begin
            rd_val = {24'h0, ctrl_d};
         end
         `RCO_SRC_IDX: begin
            rd_val = {28'h0, src_d};
         end
         `RCO_STAT_IDX: begin
            // state bits trail a control write by one cycle
            rd_val[`RCO_ST_RUN_BIT]  = (st_q == ST_RUN);
            rd_val[`RCO_ST_OUT_BIT]  = pin_q;
            rd_val[`RCO_ST_HOLD_BIT] = (st_q == ST_HOLD);
            rd_val[`RCO_ST_LIVE_BIT] = live_d;
         end
         default: begin
            rd_val = 32'h0;
         end
      endcase
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_q    <= 32'h0;
         hreadyout_q <= 1'b1;
         hresp_q     <= 1'b0;
      end else begin
         // zero wait states; every answer is okay
         hreadyout_q <= 1'b1;
         hresp_q     <= 1'b0;
         if (addr_ok && !hwrite) begin
            hrdata_q <= rd_val;
         end
      end
   end

   assign hrdata    = hrdata_q;
   assign hreadyout = hreadyout_q;
   assign hresp     = hresp_q;
endmodule
`default_nettype wire
